// [src/ces_top.sv]
/*
 * Communication error supervisor of a motor drive: debounces line faults
 * by a waiting time, applies the selected stop action, counts error
 * occurrences with hourly backup, gates error resets and picks the
 * startup operation mode. Assumes an APB master, a nonvolatile store that
 * presents its saved words in the first cycle after rst falls, and drive-side status inputs.
 */
module ces_top #(
    parameter int unsigned MS_CYCLES = ces_pkg::MS_CYC,
    parameter int unsigned HOUR_MS   = ces_pkg::HOUR_MS
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link and drive status
    input  wire logic        line_fault,
    input  wire logic        option_fault,
    input  wire logic        motor_stopped,
    input  wire logic        position_control,
    input  wire logic        torque_control,
    input  wire logic        reverse_dir,
    input  wire logic        freq_src_net,
    input  wire logic        cmd_src_external,
    input  wire logic        servo_on_input,
    input  wire logic        error_reset_req,
    input  wire logic        power_restore,
    input  wire logic        mode_req,
    input  wire logic        mode_req_net,
    input  wire logic        panel_start_we,
    input  wire logic        panel_start_val,
    input  wire logic        net_param_we,
    // Nonvolatile store
    input  wire logic [15:0] nv_count,
    input  wire logic        nv_startup,
    output logic             nv_save,
    output logic [15:0]      nv_save_data,
    output logic             nv_start_save,
    // Drive outcome
    output logic             output_shutoff,
    output logic             decel_req,
    output logic             fallback_active,
    output logic [15:0]      run_freq,
    output logic             line_error_trip,
    output logic             option_trip,
    output logic             fault_output,
    output logic             comm_fault_warning,
    output logic             network_mode,
    output logic             net_write_accept
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ces_pkg::ces_state_e st;
        logic [15:0] wait_cnt;
        logic [15:0] err_cnt;
        logic [15:0] saved;
        logic [2:0]  action;
        logic        scope;
        logic        start_sel;
        logic        spd_sel;
        logic [15:0] wait_time;
        logic [15:0] fallback;
        logic [15:0] fwd_lim;
        logic [15:0] rev_lim;
        logic [31:0] rdata;
        logic [31:0] hour_cnt;
        logic        init_done;
        logic        net_mode;
        logic        line_trip;
        logic        opt_seen;
        logic        opt_trip;
        logic        fault;
        logic        shutoff;
        logic        decel;
        logic        fb;
        logic        warn;
        logic [15:0] freq;
        logic        save;
        logic        start_save;
    } ces_state_s;

    ces_state_s r_q;
    ces_state_s r_d;
    logic       ms_tick;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_continue(input logic [2:0] a);
        return a == ces_pkg::ACT_CONTINUE;
    endfunction

    function automatic logic is_decel(input logic [2:0] a);
        return (a == ces_pkg::ACT_STOP) || (a == ces_pkg::ACT_RESTART);
    endfunction

    ces_tick #(
        .PERIOD (MS_CYCLES)
    ) u_tick (
        .mclk (mclk),
        .rst  (rst),
        .tick (ms_tick)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic rst_ok;

    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= ces_pkg::OFS_SAVED);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    // Option resets obey the scope setting
    assign rst_ok   = error_reset_req & (~r_q.scope | r_q.net_mode);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic        declared;
        logic        use_fb;
        logic [15:0] fb_freq;
        declared = 1'b0;
        use_fb   = 1'b0;
        fb_freq  = ces_pkg::ZERO16;
        r_d      = r_q;
        r_d.save       = 1'b0;
        r_d.start_save = 1'b0;

        // Restore saved count and startup mode once after reset
        if (!r_q.init_done) begin
            r_d.init_done = 1'b1;
            r_d.err_cnt   = nv_count;
            r_d.saved     = nv_count;
            r_d.start_sel = nv_startup;
            r_d.net_mode  = nv_startup;
        end else if (power_restore) begin
            r_d.net_mode = r_q.start_sel | r_q.net_mode;
        end else if (mode_req) begin
            r_d.net_mode = mode_req_net;    // Caller checks stop state
        end

        // Line supervisor
        case (r_q.st)
            ces_pkg::CES_OK: begin
                if (line_fault) begin
                    r_d.st       = ces_pkg::CES_WAIT;
                    r_d.wait_cnt = ces_pkg::ZERO16;
                    r_d.err_cnt  = r_q.err_cnt + ces_pkg::ONE16;
                end
            end
            ces_pkg::CES_WAIT: begin
                if (!line_fault) begin
                    r_d.st = ces_pkg::CES_OK;
                end else if (ms_tick) begin
                    if (r_q.wait_cnt >= r_q.wait_time) begin
                        r_d.st = ces_pkg::CES_DECL;
                    end else begin
                        r_d.wait_cnt = r_q.wait_cnt + ces_pkg::ONE16;
                    end
                end
            end
            ces_pkg::CES_DECL: begin
                declared = 1'b1;
                // Actions 2 and 6 resume on recovery; others hold until reset
                if (!line_fault && (is_continue(r_q.action)
                                    || r_q.action == ces_pkg::ACT_RESTART)) begin
                    r_d.st        = ces_pkg::CES_OK;
                    r_d.line_trip = 1'b0;
                    declared      = 1'b0;
                end else if (!line_fault && rst_ok) begin
                    r_d.st        = ces_pkg::CES_OK;
                    r_d.line_trip = 1'b0;
                    declared      = 1'b0;
                end
            end
            default: begin
                r_d.st = ces_pkg::CES_OK;
            end
        endcase

        // Option fault is latched until an accepted error reset
        if (option_fault) begin
            r_d.opt_seen = 1'b1;
        end else if (rst_ok) begin
            r_d.opt_seen = 1'b0;
            r_d.opt_trip = 1'b0;
        end

        // Stop actions on the updated latch, so a reset drops the trip
        r_d.shutoff = 1'b0;
        r_d.decel   = 1'b0;
        r_d.warn    = 1'b0;
        if (r_d.opt_seen && is_continue(r_q.action)) begin
            use_fb    = 1'b1;
            r_d.warn  = 1'b1;
        end else if (r_d.opt_seen && is_decel(r_q.action)) begin
            r_d.decel = ~motor_stopped;
            if (motor_stopped) begin
                r_d.opt_trip = 1'b1;
                r_d.shutoff  = 1'b1;
            end
        end else if (r_d.opt_seen) begin
            r_d.opt_trip = 1'b1;
            r_d.shutoff  = 1'b1;
        end
        if (declared && is_continue(r_q.action)) begin
            use_fb   = 1'b1;
            r_d.warn = 1'b1;
        end else if (declared && is_decel(r_q.action)) begin
            r_d.decel = r_d.decel | ~motor_stopped;
            if (motor_stopped) begin
                r_d.line_trip = 1'b1;
                r_d.shutoff   = 1'b1;
            end
        end else if (declared) begin
            r_d.line_trip = 1'b1;
            r_d.shutoff   = 1'b1;
        end
        // Action 2 shows the line trip after stop but keeps it off the fault output
        r_d.fault = r_d.opt_trip
                  | (r_d.line_trip & (r_q.action != ces_pkg::ACT_RESTART));

        // Fallback frequency selection
        if (torque_control && r_q.spd_sel) begin
            fb_freq = reverse_dir ? r_q.rev_lim : r_q.fwd_lim;
        end else begin
            fb_freq = r_q.fallback;
        end
        r_d.fb   = use_fb & freq_src_net & ~position_control;
        r_d.freq = r_d.fb ? fb_freq : ces_pkg::ZERO16;
        if (use_fb && position_control && cmd_src_external && !servo_on_input) begin
            r_d.shutoff = 1'b1;
        end

        // Hourly backup of the count
        if (ms_tick) begin
            if (r_q.hour_cnt >= 32'(HOUR_MS - 1)) begin
                r_d.hour_cnt = ces_pkg::ZERO32;
                r_d.save     = 1'b1;
                r_d.saved    = r_d.err_cnt;
            end else begin
                r_d.hour_cnt = r_q.hour_cnt + 32'h0000_0001;
            end
        end

        // Panel may rewrite the startup setting in any mode
        if (panel_start_we) begin
            r_d.start_sel  = panel_start_val;
            r_d.start_save = 1'b1;
        end

        // Register writes
        if (wr_en) begin
            case (paddr)
                ces_pkg::OFS_CTRL: begin
                    r_d.action     = pwdata[ces_pkg::CTL_ACT_LSB +: 3];
                    r_d.scope      = pwdata[ces_pkg::CTL_SCOPE_BIT];
                    r_d.start_sel  = pwdata[ces_pkg::CTL_START_BIT];
                    r_d.spd_sel    = pwdata[ces_pkg::CTL_SPD_BIT];
                    r_d.start_save = 1'b1;
                end
                ces_pkg::OFS_WAIT:  r_d.wait_time = pwdata[15:0];
                ces_pkg::OFS_COUNT: begin
                    if (pwdata[15:0] == ces_pkg::ZERO16) begin
                        r_d.err_cnt = ces_pkg::ZERO16;
                    end
                end
                ces_pkg::OFS_FALLB: r_d.fallback = pwdata[15:0];
                ces_pkg::OFS_FWDL:  r_d.fwd_lim  = pwdata[15:0];
                ces_pkg::OFS_REVL:  r_d.rev_lim  = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // Read data is fetched in the setup cycle
        if (rd_setup) begin
            case (paddr)
                ces_pkg::OFS_CTRL: begin
                    r_d.rdata = {25'h000_0000, r_q.spd_sel, r_q.start_sel,
                                 r_q.scope, 1'b0, r_q.action};
                end
                ces_pkg::OFS_WAIT:  r_d.rdata = {16'h0000, r_q.wait_time};
                ces_pkg::OFS_COUNT: r_d.rdata = {16'h0000, r_q.err_cnt};
                ces_pkg::OFS_FALLB: r_d.rdata = {16'h0000, r_q.fallback};
                ces_pkg::OFS_FWDL:  r_d.rdata = {16'h0000, r_q.fwd_lim};
                ces_pkg::OFS_REVL:  r_d.rdata = {16'h0000, r_q.rev_lim};
                ces_pkg::OFS_STAT: begin
                    r_d.rdata = {21'h00_0000, r_q.st, r_q.net_mode, r_q.warn,
                                 r_q.fault, r_q.opt_trip, r_q.line_trip,
                                 r_q.shutoff, r_q.decel, r_q.fb};
                end
                ces_pkg::OFS_SAVED: r_d.rdata = {16'h0000, r_q.saved};
                default:            r_d.rdata = ces_pkg::ZERO32;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q           <= '0;
            r_q.st        <= ces_pkg::CES_OK;
            r_q.wait_time <= ces_pkg::WAIT_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs
    assign prdata             = r_q.rdata;
    assign nv_save            = r_q.save;
    assign nv_save_data       = r_q.saved;
    assign nv_start_save      = r_q.start_save;
    assign output_shutoff     = r_q.shutoff;
    assign decel_req          = r_q.decel;
    assign fallback_active    = r_q.fb;
    assign run_freq           = r_q.freq;
    assign line_error_trip    = r_q.line_trip;
    assign option_trip        = r_q.opt_trip;
    assign fault_output       = r_q.fault;
    assign comm_fault_warning = r_q.warn;
    assign network_mode       = r_q.net_mode;
    assign net_write_accept   = net_param_we & r_q.net_mode;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    property p_no_trip_waiting;
        r_q.st == ces_pkg::CES_WAIT && !r_q.opt_seen |-> ##1 !fault_output;
    endproperty
    a_no_trip_waiting: assert property (p_no_trip_waiting)
        else $error("fault output during waiting time");

    property p_recover_ok;
        r_q.st == ces_pkg::CES_WAIT && !line_fault |=> r_q.st == ces_pkg::CES_OK;
    endproperty
    a_recover_ok: assert property (p_recover_ok)
        else $error("recovery did not end waiting");

    property p_declare_time;
        r_q.st == ces_pkg::CES_WAIT && r_q.wait_cnt < r_q.wait_time
            |=> r_q.st != ces_pkg::CES_DECL;
    endproperty
    a_declare_time: assert property (p_declare_time)
        else $error("error declared early");

    property p_count_inc;
        r_q.init_done && r_q.st == ces_pkg::CES_OK && line_fault && !wr_en
            |=> r_q.err_cnt == $past(r_q.err_cnt) + ces_pkg::ONE16;
    endproperty
    a_count_inc: assert property (p_count_inc)
        else $error("count not incremented");

    property p_count_clear;
        wr_en && paddr == ces_pkg::OFS_COUNT && pwdata == ces_pkg::ZERO32
            |=> r_q.err_cnt == ces_pkg::ZERO16;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("count not cleared");

    property p_opt_shutoff;
        option_fault && r_q.action == ces_pkg::ACT_SHUTOFF
            |=> output_shutoff && option_trip && fault_output;
    endproperty
    a_opt_shutoff: assert property (p_opt_shutoff)
        else $error("option fault did not shut off");

    property p_opt_continue;
        option_fault && is_continue(r_q.action) && r_q.st == ces_pkg::CES_OK
            |=> comm_fault_warning && !fault_output;
    endproperty
    a_opt_continue: assert property (p_opt_continue)
        else $error("continue action mishandled");

    property p_speed_limit;
        fallback_active && torque_control && r_q.spd_sel && !reverse_dir
            && $stable(torque_control) && $stable(reverse_dir)
            && $stable(r_q.fwd_lim) && $stable(r_q.spd_sel)
            |-> run_freq == r_q.fwd_lim;
    endproperty
    a_speed_limit: assert property (p_speed_limit)
        else $error("speed limit not used");

    property p_net_write;
        net_write_accept |-> network_mode;
    endproperty
    a_net_write: assert property (p_net_write)
        else $error("network write outside network mode");

    property p_startup_hold;
        wr_en && paddr == ces_pkg::OFS_CTRL && !power_restore && !mode_req
            && r_q.init_done |=> network_mode == $past(network_mode);
    endproperty
    a_startup_hold: assert property (p_startup_hold)
        else $error("startup setting applied at once");

    c_declared: cover property (r_q.st == ces_pkg::CES_WAIT ##1 r_q.st == ces_pkg::CES_DECL);
    c_recovered: cover property (r_q.st == ces_pkg::CES_WAIT ##1 r_q.st == ces_pkg::CES_OK);
    c_fallback: cover property (fallback_active);
    c_save: cover property (nv_save);

endmodule

// [src/ces_pkg.sv]
/*
 * Constants shared by the communication error supervisor: register map,
 * field positions, reset values, timing figures and the supervisor states.
 * Assumes a 20 MHz system clock and a 32-bit APB register bus.
 */
package ces_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_NS   = 50;          // 20 MHz clock period
    localparam int unsigned MS_NS    = 1000000;     // Wait-time unit: 1 ms
    localparam int unsigned MS_CYC   = MS_NS / CLK_NS;
    localparam int unsigned HOUR_MS  = 3600000;     // Backup interval in ms

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_WAIT  = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_FALLB = 8'h0C;
    localparam logic [7:0] OFS_FWDL  = 8'h10;
    localparam logic [7:0] OFS_REVL  = 8'h14;
    localparam logic [7:0] OFS_STAT  = 8'h18;
    localparam logic [7:0] OFS_SAVED = 8'h1C;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int unsigned CTL_ACT_LSB   = 0;      // error_stop_action [2:0]
    localparam int unsigned CTL_SCOPE_BIT = 4;      // error_reset_scope
    localparam int unsigned CTL_START_BIT = 5;      // startup_mode_select
    localparam int unsigned CTL_SPD_BIT   = 6;      // speed_limit_select

    // ------------------------------------------------------------------
    // Stop-action encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  ACT_SHUTOFF  = 3'h0;
    localparam logic [2:0]  ACT_STOP     = 3'h1;
    localparam logic [2:0]  ACT_RESTART  = 3'h2;
    localparam logic [2:0]  ACT_CONTINUE = 3'h6;
    localparam logic [15:0] WAIT_RST     = 16'h0000;
    localparam logic [15:0] ZERO16       = 16'h0000;
    localparam logic [15:0] ONE16        = 16'h0001;
    localparam logic [31:0] ZERO32       = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Line supervisor states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CES_OK   = 3'b001,   // Link healthy
        CES_WAIT = 3'b010,   // Fault seen, waiting time running
        CES_DECL = 3'b100    // Communication error declared
    } ces_state_e;

endpackage

// [src/ces_tick.sv]
/*
 * Free-running divider that emits a one-cycle pulse every PERIOD clocks.
 * Assumes one clock and an asynchronous active-high reset.
 */
module ces_tick #(
    parameter int unsigned PERIOD = 20000
) (
    input  wire logic mclk,
    input  wire logic rst,
    output logic      tick
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } ces_tick_s;

    ces_tick_s r_q;
    ces_tick_s r_d;

    // Count down to zero, reload and pulse
    always_comb begin
        r_d      = r_q;
        r_d.tick = 1'b0;
        if (r_q.cnt == ces_pkg::ZERO32) begin
            r_d.cnt  = 32'(PERIOD - 1);
            r_d.tick = 1'b1;
        end else begin
            r_d.cnt = r_q.cnt - 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign tick = r_q.tick;

endmodule

// [tb/ces_master.sv]
/* Network master model: drives the line fault level and the error reset
   pulse of the option. Assumes the bench clock and task calls. */
module ces_master (
    input  wire logic mclk,
    output logic      line_fault,
    output logic      error_reset_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        line_fault      = 1'b0;
        error_reset_req = 1'b0;
    end
    // Link down for n cycles, then healthy again
    task automatic drop(input int n);
        @(posedge mclk) line_fault <= 1'b1;
        repeat (n) @(posedge mclk);
        line_fault <= 1'b0;
    endtask
    // One-cycle reset pulse
    task automatic clr();
        @(posedge mclk) error_reset_req <= 1'b1;
        @(posedge mclk) error_reset_req <= 1'b0;
    endtask
endmodule

// [tb/ces_top_tb_top.sv]
/* Bench of the supervisor: APB driver notes expectations, a monitor
   compares reads. Assumes the master model drives the link inputs. */
module ces_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, line_fault, error_reset_req;
    logic motor_stopped, position_control, torque_control, reverse_dir, freq_src_net;
    logic cmd_src_external, servo_on_input, power_restore, mode_req, mode_req_net;
    logic panel_start_we, panel_start_val, net_param_we, nv_startup, option_fault;
    logic nv_save, nv_start_save, output_shutoff, decel_req, fallback_active;
    logic line_error_trip, option_trip, fault_output, comm_fault_warning;
    logic network_mode, net_write_accept;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] nv_count, nv_save_data, run_freq;
    logic [15:0] lf = 16'h0054;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} ces_exp_s;
    ces_exp_s q[$];
    int n_mismatch = 0;
    int n_tests = 0;
    // Short counts keep the run brief
    ces_top #(.MS_CYCLES(4), .HOUR_MS(50)) dut (.*);
    ces_master mst (.mclk(mclk), .line_fault(line_fault), .error_reset_req(error_reset_req));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic end_sim();
        if (q.size() != 0) n_mismatch++;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input ces_exp_s x);
        n_tests++;
        if ((prdata & x.m) !== x.d || pslverr !== x.e) begin
            n_mismatch++;
            $display("mismatch at %0t: addr %h read %h", $time, paddr, prdata);
        end
    endtask
    // Drive-outcome pins and frequency, looked at mid-cycle once settled
    task automatic chk_pin(input logic [31:0] x);
        @(negedge mclk);
        n_tests++;
        if ({7'h00, output_shutoff, decel_req, fallback_active, line_error_trip, option_trip,
             fault_output, comm_fault_warning, network_mode, net_write_accept,
             run_freq} !== x) begin
            n_mismatch++;
            $display("mismatch at %0t: drive pins, expected %h", $time, x);
        end
    endtask
    // Reads are judged at the completing access edge only
    always @(posedge mclk)
        if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) chk(q.pop_front());
    // One APB transfer; a read notes its expected word first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m = 0, input logic e = 0);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= w ? d : 0;
        if (!w) q.push_back('{d, m, e});
        @(posedge mclk) penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Hang guard, well beyond the 120 or so cycles needed
    initial begin
        repeat (3000) @(posedge mclk);
        $display("mismatch at %0t: timeout", $time);
        n_mismatch++;
        end_sim();
    end
    initial begin
        {psel, penable, pwrite, option_fault, motor_stopped, position_control} = '0;
        {torque_control, reverse_dir, freq_src_net, cmd_src_external, servo_on_input} = '0;
        {power_restore, mode_req, mode_req_net, panel_start_we, panel_start_val} = '0;
        {net_param_we, nv_startup, paddr, pwdata} = '0;
        nv_count = 16'hFFFF;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        apb(0, 8'h08, 32'h0000_FFFF, 32'h0000_FFFF);
        apb(1, 8'h04, 32'h0000_0002);
        lf = lfsr(lf);
        apb(1, 8'h0C, {16'h0000, lf});
        apb(0, 8'h0C, {16'h0000, lf}, 32'h0000_FFFF);
        mst.drop(2);
        repeat (4) @(posedge mclk);
        apb(0, 8'h08, 32'h0000_0000, 32'h0000_FFFF);
        apb(0, 8'h18, 32'h0000_0000, 32'h0000_0038);
        $display("short fault test done");
        apb(1, 8'h00, 32'h0000_0010);
        mst.drop(30);
        apb(0, 8'h18, 32'h0000_002C, 32'h0000_002C);
        chk_pin(32'h0128_0000);
        mst.clr();
        apb(0, 8'h18, 32'h0000_002C, 32'h0000_002C);
        apb(1, 8'h00, 32'h0000_0000);
        mst.clr();
        apb(0, 8'h18, 32'h0000_0000, 32'h0000_002C);
        apb(0, 8'h08, 32'h0000_0001, 32'h0000_FFFF);
        $display("long fault test done");
        apb(1, 8'h08, 32'h0000_0000);
        apb(0, 8'h08, 32'h0000_0000, 32'hFFFF_FFFF);
        apb(0, 8'h20, 32'h0000_0000, 32'h0000_0000, 1'b1);
        $display("counter test done");
        // Option circuit fault with action 0, then an accepted reset
        option_fault <= 1'b1;
        @(posedge mclk) option_fault <= 1'b0;
        apb(0, 8'h18, 32'h0000_0034, 32'h0000_003C);
        chk_pin(32'h0118_0000);
        mst.clr();
        apb(0, 8'h18, 32'h0000_0000, 32'h0000_003C);
        // Action 6 keeps running on the fallback frequency
        freq_src_net <= 1'b1;
        apb(1, 8'h00, 32'h0000_0006);
        option_fault <= 1'b1;
        @(posedge mclk) option_fault <= 1'b0;
        chk_pin({16'h0044, lf});
        torque_control <= 1'b1;
        apb(1, 8'h00, 32'h0000_0046);
        lf = lfsr(lf);
        apb(1, 8'h10, {16'h0000, lf});
        @(posedge mclk);
        chk_pin({16'h0044, lf});
        @(posedge mclk) freq_src_net <= 1'b0;
        @(posedge mclk);
        chk_pin(32'h0004_0000);
        mst.clr();
        $display("fallback test done");
        // Mode change only once the drive stands still
        @(posedge mclk) motor_stopped <= 1'b1;
        @(posedge mclk) mode_req <= 1'b1;
        mode_req_net <= 1'b1;
        net_param_we <= 1'b1;
        @(posedge mclk) mode_req <= 1'b0;
        chk_pin(32'h0003_0000);
        $display("mode test done");
        end_sim();
    end
endmodule
